// ---- design/dma_tc_read_throttle_debug.v ----
// read-command throttle, error re-evaluate and debug view of a dma transfer controller
//
// Contract
// - error_evaluate write pulses error line if errors
// - rate code gives 0/4/8/16/32 idle cycles
// - spacing holds within and across requests
// - rate in bits 2-0, one global value
// - active and fifo registers read-only debug
// - program set loaded by channel controller only
// - four destination fifo entry register sets
// - fifo width wraps constant-mode addresses
`timescale 1ns/1ns
`default_nettype none
`include "dma_tc_map.vh"

module dma_tc_read_throttle_debug (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdata,
    // error logic
    input  wire [3:0]  errorStatusBits,
    output reg         errorPulse,
    // channel controller program load
    input  wire        progLoad,
    input  wire [31:0] progOptions,
    input  wire [31:0] progSrcAddr,
    // channel controller read requests
    input  wire        cmdValid,
    input  wire [7:0]  cmdBytes,
    output wire        cmdReady,
    // bus endpoint read commands
    output wire        rdCmdValid,
    output reg  [31:0] rdCmdAddr,
    output reg  [7:0]  rdCmdBytes,
    input  wire        rdCmdReady,
    // destination fifo debug capture
    input  wire        dstPush,
    input  wire [31:0] dstAddr,
    // interrupt
    output wire        irq
);

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire        wrErrCmd;
    wire        wrRate;
    wire        wrIrqStat;
    wire        wrIrqMask;

    assign wrErrCmd  = regWrite && (regAddr == `ERR_CMD_OFS);
    assign wrRate    = regWrite && (regAddr == `RD_RATE_OFS);
    assign wrIrqStat = regWrite && (regAddr == `IRQ_STAT_OFS);
    assign wrIrqMask = regWrite && (regAddr == `IRQ_MASK_OFS);

    // ----------------------------------------------------------------
    // error re-evaluate
    // ----------------------------------------------------------------
    wire        evalHit;

    assign evalHit = wrErrCmd && regWdata[`ERROR_EVALUATE_BIT] && (|errorStatusBits);

    always @(posedge clock) begin
        if (!rstn) begin
            errorPulse <= 1'b0;
        end else begin
            errorPulse <= evalHit;
        end
    end

    // ----------------------------------------------------------------
    // read rate
    // ----------------------------------------------------------------
    reg  [2:0]  rate_reg;

    // stored as is; reserved codes act as full speed in the timer
    always @(posedge clock) begin
        if (!rstn) begin
            rate_reg <= `RATE_RST;
        end else if (wrRate) begin
            rate_reg <= regWdata[`RATE_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // program and source active state
    // ----------------------------------------------------------------
    reg  [31:0] srcOpt_reg;
    reg  [31:0] srcAddr_reg;
    wire [31:0] srcAddrStep;
    wire        constSrc;

    assign constSrc = srcOpt_reg[`OPT_SAM_BIT];

    addr_wrap_unit wrapUnit (
        .addrIn          (srcAddr_reg),
        .stepBytes       (cmdBytes),
        .constMode       (constSrc),
        .fifoWidthSelect (srcOpt_reg[`OPT_FIFO_WIDTH_SELECT_MSB:`OPT_FIFO_WIDTH_SELECT_LSB]),
        .addrOut         (srcAddrStep)
    );

    // the load port writes these and accepted requests step the address; software writes are ignored
    always @(posedge clock) begin
        if (!rstn) begin
            srcOpt_reg  <= `OPT_RST;
            srcAddr_reg <= 32'h0000_0000;
        end else if (progLoad) begin
            srcOpt_reg  <= progOptions & `OPT_WMASK;
            srcAddr_reg <= progSrcAddr;
        end else if (cmdValid && cmdReady) begin
            srcAddr_reg <= srcAddrStep;
        end
    end

    // ----------------------------------------------------------------
    // read command throttle
    // ----------------------------------------------------------------
    reg         hold_reg;
    wire        spaceDone;
    wire        issued;

    // one staged command; the next request waits until it is issued
    assign cmdReady   = !hold_reg && !progLoad;
    assign rdCmdValid = hold_reg && spaceDone;
    assign issued     = rdCmdValid && rdCmdReady;

    always @(posedge clock) begin
        if (!rstn) begin
            hold_reg   <= 1'b0;
            rdCmdAddr  <= 32'h0000_0000;
            rdCmdBytes <= 8'h00;
        end else if (cmdValid && cmdReady) begin
            hold_reg   <= 1'b1;
            rdCmdAddr  <= srcAddr_reg;
            rdCmdBytes <= cmdBytes;
        end else if (issued) begin
            hold_reg   <= 1'b0;
        end
    end

    // timer is never reset by a new request, so gaps span requests
    read_spacing_timer spacer (
        .clock     (clock),
        .rstn      (rstn),
        .rateCode  (rate_reg),
        .accepted  (issued),
        .spaceDone (spaceDone)
    );

    // ----------------------------------------------------------------
    // destination fifo debug entries
    // ----------------------------------------------------------------
    reg  [31:0]            dstEntry [0:`DST_DEPTH-1];
    reg  [`DST_PTR_W-1:0]  dstPtr_reg;

    always @(posedge clock) begin
        if (!rstn) begin
            dstPtr_reg <= {`DST_PTR_W{1'b0}};
        end else if (dstPush) begin
            dstPtr_reg <= dstPtr_reg + 1'b1;
        end
    end

    genvar e;
    generate
        for (e = 0; e < `DST_DEPTH; e = e + 1) begin : gDst
            always @(posedge clock) begin
                if (!rstn) begin
                    dstEntry[e] <= 32'h0000_0000;
                end else if (dstPush && (dstPtr_reg == e)) begin
                    dstEntry[e] <= dstAddr;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    reg  [`IRQ_BITS-1:0] irqStat_reg;
    reg  [`IRQ_BITS-1:0] irqStat_next;
    reg  [`IRQ_BITS-1:0] irqMask_reg;
    reg  [`IRQ_BITS-1:0] irqEvents;

    always @* begin
        irqEvents = {`IRQ_BITS{1'b0}};
        irqEvents[`IRQ_ERR_BIT]  = errorPulse;
        irqEvents[`IRQ_LOAD_BIT] = progLoad;
        irqStat_next = irqStat_reg;
        if (wrIrqStat) begin
            irqStat_next = irqStat_reg & ~regWdata[`IRQ_BITS-1:0];
        end
        // a new event wins over a clear in the same cycle
        irqStat_next = irqStat_next | irqEvents;
    end

    always @(posedge clock) begin
        if (!rstn) begin
            irqStat_reg <= `IRQ_RST;
            irqMask_reg <= `IRQ_RST;
        end else begin
            irqStat_reg <= irqStat_next;
            if (wrIrqMask) begin
                irqMask_reg <= regWdata[`IRQ_BITS-1:0];
            end
        end
    end

    assign irq = |(irqStat_reg & irqMask_reg);

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    reg  [31:0] readMux;

    always @* begin
        readMux = 32'h0000_0000;
        case (regAddr)
            `ERR_CMD_OFS:  readMux = 32'h0000_0000;
            `RD_RATE_OFS:  readMux = {29'h0000_0000, rate_reg};
            `SRC_OPT_OFS:  readMux = srcOpt_reg;
            `SRC_ADDR_OFS: readMux = srcAddr_reg;
            `IRQ_STAT_OFS: readMux = {30'h0000_0000, irqStat_reg};
            `IRQ_MASK_OFS: readMux = {30'h0000_0000, irqMask_reg};
            `DST_BASE_OFS: readMux = dstEntry[0];
            `DST_BASE_OFS + `DST_STRIDE: readMux = dstEntry[1];
            `DST_BASE_OFS + 8'h08:       readMux = dstEntry[2];
            `DST_BASE_OFS + 8'h0C:       readMux = dstEntry[3];
            default:       readMux = 32'h0000_0000;
        endcase
    end

    always @(posedge clock) begin
        if (!rstn) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            regRdata <= readMux;
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

endmodule // dma_tc_read_throttle_debug

`default_nettype wire

// ---- design/dma_tc_map.vh ----
// register offsets, field layouts and timing counts of the read throttle block
`ifndef DMA_TC_MAP_VH
`define DMA_TC_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ERR_CMD_OFS        8'h00
`define RD_RATE_OFS        8'h04
`define SRC_OPT_OFS        8'h08
`define SRC_ADDR_OFS       8'h0C
`define IRQ_STAT_OFS       8'h10
`define IRQ_MASK_OFS       8'h14
`define DST_BASE_OFS       8'h20
`define DST_STRIDE         8'h04

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define ERROR_EVALUATE_BIT           0
`define RATE_MSB           2
`define RATE_RST           3'h0
`define OPT_RST            32'h0000_0000
`define OPT_WMASK          32'h0053_F773
`define OPT_SAM_BIT        0
`define OPT_DAM_BIT        1
`define OPT_FIFO_WIDTH_SELECT_LSB       8
`define OPT_FIFO_WIDTH_SELECT_MSB       10
`define IRQ_ERR_BIT        0
`define IRQ_LOAD_BIT       1
`define IRQ_BITS           2
`define IRQ_RST            2'h0

// ----------------------------------------------------------------
// spacing codes and idle counts, destination fifo
// ----------------------------------------------------------------
`define RATE_FAST          3'h0
`define RATE_4             3'h1
`define RATE_8             3'h2
`define RATE_16            3'h3
`define RATE_32            3'h4
`define IDLE_4             6'h04
`define IDLE_8             6'h08
`define IDLE_16            6'h10
`define IDLE_32            6'h20
`define IDLE_NONE          6'h00
`define DST_DEPTH          4
`define DST_PTR_W          2

`endif

// ---- design/read_spacing_timer.v ----
// idle-cycle counter that spaces successive read commands
`timescale 1ns/1ns
`default_nettype none
`include "dma_tc_map.vh"

module read_spacing_timer (
    // clock and reset
    input  wire       clock,
    input  wire       rstn,
    // control
    input  wire [2:0] rateCode,
    input  wire       accepted,
    // status
    output wire       spaceDone
);

    reg  [5:0] count_reg;
    reg  [5:0] count_next;
    reg  [5:0] idleCycles;

    // reserved codes fall back to full speed
    always @* begin
        case (rateCode)
            `RATE_4:  idleCycles = `IDLE_4;
            `RATE_8:  idleCycles = `IDLE_8;
            `RATE_16: idleCycles = `IDLE_16;
            `RATE_32: idleCycles = `IDLE_32;
            default:  idleCycles = `IDLE_NONE;
        endcase
    end

    always @* begin
        count_next = count_reg;
        if (accepted) begin
            count_next = idleCycles;
        end else if (count_reg != `IDLE_NONE) begin
            count_next = count_reg - 6'h01;
        end
    end

    always @(posedge clock) begin
        if (!rstn) begin
            count_reg <= `IDLE_NONE;
        end else begin
            count_reg <= count_next;
        end
    end

    assign spaceDone = (count_reg == `IDLE_NONE);

endmodule // read_spacing_timer

`default_nettype wire

// ---- design/addr_wrap_unit.v ----
// next source address, wrapping inside the fifo width in constant mode
`timescale 1ns/1ns
`default_nettype none
`include "dma_tc_map.vh"

module addr_wrap_unit (
    // inputs
    input  wire [31:0] addrIn,
    input  wire [7:0]  stepBytes,
    input  wire        constMode,
    input  wire [2:0]  fifoWidthSelect,
    // output
    output reg  [31:0] addrOut
);

    reg [31:0] sum;
    reg [31:0] wrapMask;

    always @* begin
        sum = addrIn + {24'h00_0000, stepBytes};
        case (fifoWidthSelect)
            3'h0:    wrapMask = 32'h0000_0000;
            3'h1:    wrapMask = 32'h0000_0001;
            3'h2:    wrapMask = 32'h0000_0003;
            3'h3:    wrapMask = 32'h0000_0007;
            3'h4:    wrapMask = 32'h0000_000F;
            default: wrapMask = 32'h0000_0000;
        endcase
        // constant mode keeps the upper bits, only the lane offset moves
        if (constMode) begin
            addrOut = (addrIn & ~wrapMask) | (sum & wrapMask);
        end else begin
            addrOut = sum;
        end
    end

endmodule // addr_wrap_unit

`default_nettype wire

// ---- verif/rd_endpoint_model.sv ----
// bus endpoint model that accepts throttled read commands
`timescale 1ns/1ns
`default_nettype none

module rd_endpoint_model (
    // clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // read command
    input  wire logic rdCmdValid,
    input  wire logic stall,
    output var  logic rdCmdReady
);
    logic [1:0] waitCnt;
    // stall mode keeps each command waiting three cycles
    always @(posedge clock) begin
        if (!rstn || !rdCmdValid || rdCmdReady)
            waitCnt <= 2'h0;
        else if (waitCnt != 2'h3)
            waitCnt <= waitCnt + 2'h1;
    end
    assign rdCmdReady = rdCmdValid && (!stall || waitCnt == 2'h3);
endmodule // rd_endpoint_model
`default_nettype wire

// ---- verif/dma_tc_read_throttle_debug_asserts.sv ----
// port-level checker of the read throttle block
`timescale 1ns/1ns
`default_nettype none

module dma_tc_read_throttle_debug_asserts (
    // clock, reset, registers
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    // error and commands
    input wire logic [3:0]  errorStatusBits,
    input wire logic        errorPulse,
    input wire logic        progLoad,
    input wire logic        cmdValid,
    input wire logic [7:0]  cmdBytes,
    input wire logic        cmdReady,
    input wire logic        rdCmdValid,
    input wire logic [31:0] rdCmdAddr,
    input wire logic [7:0]  rdCmdBytes,
    input wire logic        rdCmdReady
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [2:0] rateM;
    logic [5:0] gapCnt;
    logic [5:0] needCnt;
    // shadow of the spacing code; valid while software keeps it static
    always @(posedge clock) begin
        if (!rstn)
            rateM <= 3'h0;
        else if (regWrite && regAddr == 8'h04)
            rateM <= regWdata[2:0];
    end
    always @(posedge clock) begin
        if (!rstn)
            gapCnt <= 6'h3F;
        else if (rdCmdValid && rdCmdReady)
            gapCnt <= 6'h00;
        else if (gapCnt != 6'h3F)
            gapCnt <= gapCnt + 6'h01;
    end
    assign needCnt = (rateM >= 3'h1 && rateM <= 3'h4) ? 6'h02 << rateM : 6'h00;

    a_error_evaluate_pulse:
        assert property (regWrite && regAddr == 8'h00 && regWdata[0] && |errorStatusBits
            |=> errorPulse) else $error("missing error pulse");
    a_pulse_cause:
        assert property (errorPulse |-> $past(regWrite && regAddr == 8'h00 && regWdata[0]
            && |errorStatusBits)) else $error("spurious error pulse");
    a_error_evaluate_reads:
        assert property (regRead && regAddr == 8'h00 |=> regRdata == 32'h0000_0000)
            else $error("command register read not zero");
    a_rate_read:
        assert property (regRead && regAddr == 8'h04 |=> regRdata == {29'h0, rateM})
            else $error("rate readback wrong");
    a_rate_space:
        assert property (rdCmdValid |-> gapCnt >= needCnt) else $error("read too early");
    a_cmd_hold:
        assert property (rdCmdValid && !rdCmdReady |=> rdCmdValid && $stable(rdCmdAddr)
            && $stable(rdCmdBytes)) else $error("read command dropped");
    a_load_blocks:
        assert property (progLoad || rdCmdValid |-> !cmdReady) else $error("take while busy");
    a_stage_issue:
        assert property (cmdValid && cmdReady |-> ##[1:33] rdCmdValid)
            else $error("staged read never offered");
    a_bytes_stage:
        assert property (cmdValid && cmdReady |=> rdCmdBytes == $past(cmdBytes))
            else $error("byte count not staged");
    c_pulse: cover property (errorPulse);
    c_stall: cover property (rdCmdValid && !rdCmdReady);
    c_slow: cover property (rdCmdValid && rdCmdReady && needCnt == 6'h20);
endmodule // dma_tc_read_throttle_debug_asserts

bind dma_tc_read_throttle_debug dma_tc_read_throttle_debug_asserts chk (.clock, .rstn,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .errorStatusBits, .errorPulse,
    .progLoad, .cmdValid, .cmdBytes, .cmdReady, .rdCmdValid, .rdCmdAddr, .rdCmdBytes,
    .rdCmdReady);
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench of the read throttle, error command and debug view
`timescale 1ns/1ns
`default_nettype none
`include "dma_tc_map.vh"

module tb_top;
    logic        clock = 1'b0, rstn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0]  regAddr = 8'h00, cmdBytes = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000, progSrcAddr = 32'h0000_0000;
    logic [31:0] progOptions = 32'hFFFF_FFFE, dstAddr = 32'h0000_0000;
    logic [3:0]  errorStatusBits = 4'h0;
    logic        progLoad = 1'b0, cmdValid = 1'b0, dstPush = 1'b0, stall = 1'b0;
    wire         errorPulse, cmdReady, rdCmdValid, rdCmdReady, irq;
    wire  [31:0] regRdata, rdCmdAddr;
    wire  [7:0]  rdCmdBytes;
    int          errorCnt = 0, totalChecks = 0, cyc = 0, nIss = 0;
    int          issT [16];
    logic [31:0] issA [16];

    dma_tc_read_throttle_debug DUT (.clock, .rstn, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .errorStatusBits, .errorPulse, .progLoad, .progOptions,
        .progSrcAddr, .cmdValid, .cmdBytes, .cmdReady, .rdCmdValid, .rdCmdAddr,
        .rdCmdBytes, .rdCmdReady, .dstPush, .dstAddr, .irq);
    rd_endpoint_model endpoint (.clock, .rstn, .rdCmdValid, .stall, .rdCmdReady);

    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (rdCmdValid && rdCmdReady) begin
            issT[nIss] <= cyc;
            issA[nIss] <= rdCmdAddr;
            nIss <= nIss + 1;
        end
    end

    // ---
    // access tasks
    // ---
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(posedge clock);
        check(regRdata, exp);
    endtask
    task automatic ev(input logic [3:0] s, input logic [31:0] d, input logic e);
        @(posedge clock);
        errorStatusBits <= s;
        wr(`ERR_CMD_OFS, d);
        #1;
        chk1(errorPulse, e);
    endtask
    task automatic load(input logic [31:0] a);
        @(posedge clock);
        progLoad <= 1'b1;
        progSrcAddr <= a;
        @(posedge clock);
        progLoad <= 1'b0;
    endtask
    task automatic send(input logic [7:0] b);
        int n = 0;
        @(posedge clock);
        cmdValid <= 1'b1;
        cmdBytes <= b;
        do begin
            @(posedge clock);
            n++;
        end while (!cmdReady && n < 50);
        cmdValid <= 1'b0;
    endtask
    task automatic waitIss(input int k);
        int n = 0;
        while (nIss < k && n < 200) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic close_out;
        if (errorCnt == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ---
    // tests
    // ---
    initial begin
        int gap, need;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rd(`RD_RATE_OFS, 32'h0000_0000);
        wr(`RD_RATE_OFS, 32'hFFFF_FFFF);
        rd(`RD_RATE_OFS, 32'h0000_0007);
        rd(8'h40, 32'h0000_0000);
        ev(4'h0, 32'h0000_0001, 1'b0);
        ev(4'h3, 32'h0000_0000, 1'b0);
        ev(4'h4, 32'h0000_0001, 1'b1);
        ev(4'h8, 32'h0000_0003, 1'b1);
        chk1(irq, 1'b0);
        wr(`IRQ_MASK_OFS, 32'h0000_0001);
        #1 chk1(irq, 1'b1);
        wr(`IRQ_STAT_OFS, 32'h0000_0001);
        #1 chk1(irq, 1'b0);
        for (int i = 0; i < 5; i++) begin
            // rate changed only while idle
            wr(`RD_RATE_OFS, 32'(i));
            stall <= (i == 0);
            load(32'h0000_1000 << i);
            send(8'h08);
            waitIss(2 * i + 1);
            load(32'h0000_8000);
            send(8'h04);
            waitIss(2 * i + 2);
            #1;
            gap = issT[2 * i + 1] - issT[2 * i];
            need = (i == 0) ? 0 : 2 << i;
            chk1(gap > need && (need < 8 || gap == need + 1), 1'b1);
            check(issA[2 * i], 32'h0000_1000 << i);
            check(issA[2 * i + 1], 32'h0000_8000);
            repeat (40) @(posedge clock);
        end
        rd(`SRC_OPT_OFS, `OPT_WMASK & 32'hFFFF_FFFE);
        wr(`SRC_OPT_OFS, 32'h0000_0000);
        rd(`SRC_OPT_OFS, `OPT_WMASK & 32'hFFFF_FFFE);
        rd(`SRC_ADDR_OFS, 32'h0000_8004);
        // constant mode on a 32-bit lane: the step must wrap inside the word
        progOptions <= 32'h0000_0201;
        load(32'h0000_2003);
        send(8'h01);
        waitIss(11);
        check(issA[10], 32'h0000_2003);
        rd(`SRC_ADDR_OFS, 32'h0000_2000);
        rd(`SRC_OPT_OFS, 32'h0000_0201);
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            dstPush <= 1'b1;
            dstAddr <= 32'hA000_0000 + 32'(i);
        end
        @(posedge clock);
        dstPush <= 1'b0;
        for (int i = 0; i < 4; i++)
            rd(`DST_BASE_OFS + 8'(4 * i), 32'hA000_0000 + 32'(i == 0 ? 4 : i));
        close_out;
    end

    initial begin
        #200000;
        errorCnt++;
        close_out;
    end
endmodule // tb_top
`default_nettype wire
